/* File: relay_cond_pkg.sv */
// relay_cond_pkg: constants for the relay output conditioner
// assumes a 40 MHz core clock and an apb register bus
package relay_cond_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned NUM_RELAYS = 6;
  localparam int unsigned HOLD_MAX_MS = 9999;
  localparam int unsigned ACT_MAX_MS = 60000;
  // register byte addresses
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CMD = 12'h008;
  localparam logic [11:0] OFS_RELAY0 = 12'h010;
  localparam logic [11:0] OFS_RSTRIDE = 12'h010;
  // per-relay word 0: assignment, polarity, fallback
  // per-relay word 1: activation delay, word 2: holding time
  localparam int unsigned FLD_ASSIGN_LSB = 0;
  localparam int unsigned FLD_POL = 8;
  localparam int unsigned FLD_FBK = 9;
  // assignment codes
  localparam logic [7:0] ASG_NONE = 8'h00;
  localparam logic [7:0] ASG_FAULT = 8'h01;
  localparam logic [7:0] ASG_MAINS = 8'h02;
  localparam logic [7:0] ASG_DCCHG = 8'h03;
  localparam logic [7:0] ASG_BRAKE = 8'h04;
  localparam logic [7:0] ASG_OUTCON = 8'h05;
  localparam logic [7:0] ASG_EVENT = 8'h06;
  // reset values
  localparam logic RST_POL = 1'b1;
  localparam logic RST_FBK = 1'b0;
  localparam logic [15:0] RST_DELAY = 16'h0000;
endpackage

/* File: relay_output_conditioner.sv */
// relay_output_conditioner: six relay outputs with delays, polarity
// and fallback; assumes event/fault inputs are pins, synchronised here
//
// Overview of operation
// - active level 1 drives relay high on event
// - protected assignments other than output contactor force positive active level
// - event false: hold state for holding time
// - holding time 0..9999 ms, default zero
// - protected assignments fix holding time at zero
// - fallback forced off when relay assigned
// - no fallback: assignment or command bit, errors ignored
// - fallback: command bit, error drives disabled
// - delays and polarity still apply under fallback
// - fault never clears non-fallback command output
// - activation delay 0..60000 ms, protected forced zero
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module relay_output_conditioner (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // drive event sources, one per assignment code 1..5; ASG_EVENT uses the bit of the relay's own index
  input wire logic [7:0] i_event_src,
  input wire logic i_error,
  // relay driver
  output logic [5:0] o_relay
);
  localparam int N = relay_cond_pkg::NUM_RELAYS;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [8:0] s1_q, s2_q, s3_q, in_q;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      s3_q <= 9'h000;
      in_q <= 9'h000;
    end else begin
      s1_q <= {i_error, i_event_src};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < 9; k++) begin
        if (s2_q[k] == s3_q[k]) in_q[k] <= s3_q[k];
      end
    end
  end
  logic [7:0] ev;
  logic err;
  assign ev = in_q[7:0];
  assign err = in_q[8];

  // ------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------
  localparam logic [15:0] TICK_LAST =
    16'(relay_cond_pkg::TICK_CYCLES - 1);
  logic [15:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 16'h0000
                                               : tick_cnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [7:0] asg_q [N];
  logic pol_q [N];
  logic fbk_q [N];
  logic [15:0] act_q [N];
  logic [15:0] hold_q [N];
  logic [5:0] cmd_q;
  logic apb_wr;
  assign apb_wr = i_psel && i_penable && i_pwrite;

  function automatic logic prot4(input logic [7:0] a);
    prot4 = (a == relay_cond_pkg::ASG_FAULT) ||
            (a == relay_cond_pkg::ASG_MAINS) ||
            (a == relay_cond_pkg::ASG_DCCHG) ||
            (a == relay_cond_pkg::ASG_BRAKE);
  endfunction
  function automatic logic prot5(input logic [7:0] a);
    prot5 = prot4(a) || (a == relay_cond_pkg::ASG_OUTCON);
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmd_q <= 6'h00;
      for (int r = 0; r < N; r++) begin
        asg_q[r] <= relay_cond_pkg::ASG_NONE;
        pol_q[r] <= relay_cond_pkg::RST_POL;
        fbk_q[r] <= relay_cond_pkg::RST_FBK;
        act_q[r] <= relay_cond_pkg::RST_DELAY;
        hold_q[r] <= relay_cond_pkg::RST_DELAY;
      end
    end else begin
      if (apb_wr && i_paddr == relay_cond_pkg::OFS_CMD) begin
        cmd_q <= i_pwdata[5:0];
      end
      for (int r = 0; r < N; r++) begin
        if (apb_wr && i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
            + r * relay_cond_pkg::OFS_RSTRIDE)) begin
          asg_q[r] <= i_pwdata[7:0];
          pol_q[r] <= i_pwdata[relay_cond_pkg::FLD_POL];
          fbk_q[r] <= i_pwdata[relay_cond_pkg::FLD_FBK];
        end else if (apb_wr && i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
            + r * relay_cond_pkg::OFS_RSTRIDE + 4)) begin
          if (!prot5(asg_q[r]) &&
              i_pwdata[15:0] <= 16'(relay_cond_pkg::ACT_MAX_MS))
            act_q[r] <= i_pwdata[15:0];
        end else if (apb_wr && i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
            + r * relay_cond_pkg::OFS_RSTRIDE + 8)) begin
          if (!prot5(asg_q[r]) &&
              i_pwdata[15:0] <= 16'(relay_cond_pkg::HOLD_MAX_MS))
            hold_q[r] <= i_pwdata[15:0];
        end
      end
    end
  end

  // effective settings after forcing
  logic eff_pol [N];
  logic eff_fbk [N];
  logic [15:0] eff_act [N];
  logic [15:0] eff_hold [N];
  always_comb begin
    for (int r = 0; r < N; r++) begin
      eff_pol[r] = prot4(asg_q[r]) ? 1'b1 : pol_q[r];
      eff_fbk[r] = (asg_q[r] == relay_cond_pkg::ASG_NONE) && fbk_q[r];
      eff_act[r] = prot5(asg_q[r]) ? 16'h0000 : act_q[r];
      eff_hold[r] = prot5(asg_q[r]) ? 16'h0000 : hold_q[r];
    end
  end

  // ------------------------------------------------------------
  // per-relay logical state with delays
  // ------------------------------------------------------------
  logic req [N];
  logic state_q [N];
  logic [15:0] dly_q [N];
  logic pend_q [N];
  always_comb begin
    for (int r = 0; r < N; r++) begin
      if (eff_fbk[r])
        req[r] = err ? 1'b0 : cmd_q[r];
      else if (asg_q[r] == relay_cond_pkg::ASG_NONE)
        req[r] = cmd_q[r];
      else if (asg_q[r] == relay_cond_pkg::ASG_EVENT)
        req[r] = ev[r];
      else
        req[r] = ev[asg_q[r][2:0]];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int r = 0; r < N; r++) begin
        state_q[r] <= 1'b0;
        dly_q[r] <= 16'h0000;
        pend_q[r] <= 1'b0;
      end
    end else begin
      for (int r = 0; r < N; r++) begin
        if (req[r] == state_q[r]) begin
          pend_q[r] <= 1'b0;
          dly_q[r] <= 16'h0000;
        end else if (!pend_q[r]) begin
          pend_q[r] <= 1'b1;
          dly_q[r] <= 16'h0000;
          if ((req[r] ? eff_act[r] : eff_hold[r]) == 16'h0000) begin
            state_q[r] <= req[r];
            pend_q[r] <= 1'b0;
          end
        end else if (tick_q) begin
          if (dly_q[r] + 16'h0001 >=
              (req[r] ? eff_act[r] : eff_hold[r])) begin
            state_q[r] <= req[r];
            pend_q[r] <= 1'b0;
          end else begin
            dly_q[r] <= dly_q[r] + 16'h0001;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_relay <= 6'h00;
    end else begin
      for (int r = 0; r < N; r++)
        o_relay[r] <= eff_pol[r] ? state_q[r] : !state_q[r];
    end
  end

  // ------------------------------------------------------------
  // apb read side
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (i_paddr == relay_cond_pkg::OFS_CMD) begin
          o_prdata <= {26'h0, cmd_q};
        end else if (i_paddr == relay_cond_pkg::OFS_STATUS) begin
          o_prdata <= {23'h0, err, 2'h0, o_relay};
        end else begin
          for (int r = 0; r < N; r++) begin
            if (i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
                + r * relay_cond_pkg::OFS_RSTRIDE))
              o_prdata <= {22'h0, eff_fbk[r], eff_pol[r], asg_q[r]};
            if (i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
                + r * relay_cond_pkg::OFS_RSTRIDE + 4))
              o_prdata <= {16'h0, eff_act[r]};
            if (i_paddr == 12'(relay_cond_pkg::OFS_RELAY0
                + r * relay_cond_pkg::OFS_RSTRIDE + 8))
              o_prdata <= {16'h0, eff_hold[r]};
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_pol;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !$past(i_sys_rst) |-> o_relay[0] ==
        ($past(eff_pol[0]) ? $past(state_q[0]) : !$past(state_q[0]));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity wrong");
  property p_prot_pol;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (prot4(asg_q[0]) && !$past(i_sys_rst) && $past(asg_q[0]) == asg_q[0])
        |-> o_relay[0] == $past(state_q[0]);
  endproperty
  a_prot_pol: assert property (p_prot_pol) else $error("pol not forced");
  property p_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (pend_q[0] && state_q[0] && !req[0] && !tick_q) |=> state_q[0];
  endproperty
  a_hold: assert property (p_hold) else $error("hold broken");
  property p_hold_rng;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      hold_q[0] <= 16'd9999;
  endproperty
  a_hold_rng: assert property (p_hold_rng) else $error("hold range");
  property p_prot_dly;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (prot5(asg_q[0]) && !pend_q[0] && req[0] != state_q[0])
        |=> state_q[0] == $past(req[0]);
  endproperty
  a_prot_dly: assert property (p_prot_dly) else $error("dly not 0");
  property p_fbk_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (asg_q[0] != relay_cond_pkg::ASG_NONE &&
       asg_q[0] != relay_cond_pkg::ASG_EVENT)
        |-> req[0] == ev[asg_q[0][2:0]];
  endproperty
  a_fbk_off: assert property (p_fbk_off) else $error("fbk not off");
  property p_fbk_err;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (eff_fbk[0] && err && state_q[0] && !pend_q[0] && eff_hold[0] == 16'h0)
        |=> !state_q[0];
  endproperty
  a_fbk_err: assert property (p_fbk_err) else $error("err no clear");
  property p_nofbk;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!eff_fbk[0] && asg_q[0] == relay_cond_pkg::ASG_NONE && err &&
       cmd_q[0] && state_q[0]) |=> state_q[0];
  endproperty
  a_nofbk: assert property (p_nofbk) else $error("cmd not used");
  property p_zero_act;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (req[0] && !state_q[0] && !pend_q[0] && eff_act[0] == 16'h0)
        |=> state_q[0];
  endproperty
  a_zero_act: assert property (p_zero_act) else $error("no delay 0");
  c_on: cover property (@(posedge i_core_clk) $rose(o_relay[0]));
  c_fbk: cover property (@(posedge i_core_clk) eff_fbk[0] && err);
  c_restart: cover property (@(posedge i_core_clk)
    pend_q[0] && req[0] == state_q[0]);
endmodule // relay_output_conditioner

/* File: relay_output_conditioner_tb.sv */
// relay_output_conditioner_tb: table of relay cases, then register
// ranges, forced values and holding time; apb master in the bench
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module relay_output_conditioner_tb;
  typedef struct packed {
    logic [7:0] asg;
    logic pol;
    logic fbk;
    logic [7:0] ev;
    logic err;
    logic cmd;
    logic rly;
    logic [11:0] rb;
  } row_t;
  localparam row_t ROWS [13] = '{
    '{8'h06, 1'b1, 1'b0, 8'h01, 1'b0, 1'b0, 1'b1, 12'h106},
    '{8'h06, 1'b0, 1'b0, 8'h01, 1'b0, 1'b0, 1'b0, 12'h006},
    '{8'h06, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 12'h006},
    '{8'h01, 1'b0, 1'b1, 8'h02, 1'b0, 1'b0, 1'b1, 12'h101},
    '{8'h02, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 12'h102},
    '{8'h03, 1'b0, 1'b0, 8'h08, 1'b0, 1'b0, 1'b1, 12'h103},
    '{8'h04, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 12'h104},
    '{8'h05, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 12'h005},
    '{8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 12'h100},
    '{8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 1'b1, 1'b1, 12'h100},
    '{8'h00, 1'b1, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1, 12'h300},
    '{8'h00, 1'b1, 1'b1, 8'h00, 1'b1, 1'b1, 1'b0, 12'h300},
    '{8'h00, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1, 1'b1, 12'h200}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic slverr;
  logic [7:0] ev = 8'h00;
  logic err = 1'b0;
  logic [7:0] ev_pin;
  logic err_pin;
  logic [5:0] relay;
  logic [5:0] coil;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  relay_output_conditioner uut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(slverr), .i_event_src(ev_pin), .i_error(err_pin),
    .o_relay(relay)
  );
  relay_partner_model partner (
    .i_core_clk(clk), .i_ev_set(ev), .i_err_set(err),
    .o_event_src(ev_pin), .o_error(err_pin), .i_relay(relay),
    .o_coil(coil)
  );
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    `CHK("pslverr", 1'b0, slverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_relay(input logic e, input int lim);
    int n;
    n = 0;
    while (coil[0] !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    `CHK("relay0", e, coil[0])
  endtask
  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      errors++;
      end_sim;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("relay_rst", 6'h00, relay)
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h014, 32'h0, q);
    `CHK("act_rst", 32'h0, q)
    apb(1'b0, 12'h018, 32'h0, q);
    `CHK("hold_rst", 32'h0, q)
    apb(1'b0, 12'h100, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    $display("test reset done");
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, 12'h010, {22'h0, ROWS[i].fbk, ROWS[i].pol,
          ROWS[i].asg}, q);
      apb(1'b1, 12'h008, {31'h0, ROWS[i].cmd}, q);
      ev <= ROWS[i].ev;
      err <= ROWS[i].err;
      apb(1'b0, 12'h010, 32'h0, q);
      `CHK("cfg0", {20'h0, ROWS[i].rb}, q)
      repeat (12) @(negedge clk);
      wait_relay(ROWS[i].rly, 40);
      apb(1'b0, 12'h004, 32'h0, q);
      `CHK("status", {23'h0, ROWS[i].err, 7'h0, ROWS[i].rly}, q)
    end
    $display("test table done");
    apb(1'b1, 12'h010, 32'h0, q);
    apb(1'b1, 12'h018, 32'h270f, q);
    apb(1'b1, 12'h018, 32'h2710, q);
    apb(1'b0, 12'h018, 32'h0, q);
    `CHK("hold_max", 32'h270f, q)
    apb(1'b1, 12'h014, 32'hea60, q);
    apb(1'b1, 12'h014, 32'hea61, q);
    apb(1'b0, 12'h014, 32'h0, q);
    `CHK("act_max", 32'hea60, q)
    apb(1'b1, 12'h010, 32'h1, q);
    apb(1'b1, 12'h018, 32'h5, q);
    apb(1'b0, 12'h018, 32'h0, q);
    `CHK("hold_forced", 32'h0, q)
    apb(1'b0, 12'h014, 32'h0, q);
    `CHK("act_forced", 32'h0, q)
    $display("test ranges done");
    apb(1'b1, 12'h010, 32'h106, q);
    apb(1'b1, 12'h014, 32'h0, q);
    apb(1'b1, 12'h018, 32'h2, q);
    ev <= 8'h01;
    err <= 1'b0;
    wait_relay(1'b1, 40);
    @(posedge clk);
    ev <= 8'h00;
    repeat (20000) @(posedge clk);
    `CHK("hold_mid", 1'b1, coil[0])
    wait_relay(1'b0, 70000);
    $display("test hold done");
    end_sim;
  end
endmodule // relay_output_conditioner_tb

/* File: relay_partner_model.sv */
// relay_partner_model: event sources, error line and relay driver
// assumes the bench clock; requests are applied on rising edges
`timescale 1ns/1ps
module relay_partner_model (
  // clock
  input wire logic i_core_clk,
  // bench requests
  input wire logic [7:0] i_ev_set,
  input wire logic i_err_set,
  // toward the conditioner
  output logic [7:0] o_event_src,
  output logic o_error,
  input wire logic [5:0] i_relay,
  // relay coils as driven
  output logic [5:0] o_coil
);
  initial begin
    o_event_src = 8'h00;
    o_error = 1'b0;
    o_coil = 6'h00;
  end
  always @(posedge i_core_clk) begin
    o_event_src <= i_ev_set;
    o_error <= i_err_set;
    o_coil <= i_relay;
  end
endmodule // relay_partner_model
